// ---- rtl/sim_core.sv ----
// Program interrupt dispatch and motion command decoding.
// Assumes a classic Wishbone master and a same-clock byte link to the host.
// Summary of operation
// (R1) Timers 0-2, position reached 3-5
// (R2) Stall 15-17, deviation 21-23
// (R3) Limit switches 27-32, input change 39-46
// (R4) Number 255 is the global enable
// (R5) Divert only if pending, enabled, vectored
// (R6) Save accumulator, X and flags first
// (R7) No nesting while a handler runs
// (R8) Return restores context and resumes program
// (R9) Global bank 3 configures interrupts
// (R10) Program vectors, configures, enables, then globally
// (R11) Handlers end with the return instruction
// (R12) Main flow never falls into handlers
// (R13) Right: velocity mode, then parameter 2
// (R14) Left: velocity mode, negated parameter 2
// (R15) Type 0, axis 0-2, velocity within 2047
// (R16) Stop: velocity mode, target speed zero
// (R17) Frame: address, instr, type, axis, value, sum
// (R18) Good motion commands reply status 100
// (R19) Codes: enable 25, disable 26, vector 37, return 38
// (R20) Host frames never touch the accumulator
// (R21) Checksum is byte sum of eight bytes
// (R22) Rotate right 1, rotate left 2
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
module sim_core #(
  parameter logic [7:0] MODULE_ADDR = 8'h01,
  parameter logic [7:0] REPLY_ADDR  = 8'h02,
  parameter int         TICK_CYCLES = sim_pkg::TICK_CYCLES,
  parameter int         TIMER_W     = 16
) (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic [7:0]  RX_BYTE_I,
  input  wire logic        RX_VALID_I,
  output logic             RX_READY_O,
  output logic      [7:0]  TX_BYTE_O,
  output logic             TX_VALID_O,
  input  wire logic        TX_READY_I,
  input  wire logic [2:0]  EVT_POS_I,
  input  wire logic [2:0]  EVT_STALL_I,
  input  wire logic [2:0]  EVT_DEV_I,
  input  wire logic [5:0]  STOP_SW_I,
  input  wire logic [7:0]  IN_PIN_I,
  output logic             MODE_STB_O,
  output logic      [1:0]  AXIS_O,
  output logic             PAR_STB_O,
  output logic      [7:0]  PAR_NUM_O,
  output logic      [31:0] PAR_VAL_O,
  output logic      [2:0]  VEL_MODE_O,
  output logic             IRQ_ACTIVE_O
);
  localparam int NSRC = sim_pkg::NSRC;
  localparam int NP   = sim_pkg::NPINS;

  initial
  begin
    if (TICK_CYCLES < 2 || TIMER_W < 1 || TIMER_W > 32)
      $error("Unsupported parameter value");
  end

  // Register bus decode
  logic        wr, cmd_exec, irq_return_cmd_exec, take;
  logic [7:0]  op, typ, bank;
  logic [NSRC-1:0] match, req, evt;
  logic [4:0]  sel;
  logic [31:0] value_r;
  // Writes land on the edge where the master sees ack
  assign wr        = CYC_I && STB_I && ACK_O && WE_I;
  assign op        = DAT_I[7:0];
  assign typ       = DAT_I[15:8];
  assign bank      = DAT_I[23:16];
  assign cmd_exec  = wr && ADR_I == sim_pkg::OFS_CMD && (&SEL_I[2:0]);
  assign irq_return_cmd_exec = cmd_exec && op == sim_pkg::OP_IRQ_RETURN && IRQ_ACTIVE_O; // [R19]

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // Pin synchronisers with change detection
  logic [NP-1:0] pin_s1, pin_s2, pin_s3, pin_lvl, pin_chg;
  genvar g;
  for (g = 0; g < NP; g++)
  begin : g_pin
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
      if (!RSTN_I)
      begin
        pin_s1[g]  <= 1'b0;
        pin_s2[g]  <= 1'b0;
        pin_s3[g]  <= 1'b0;
        pin_lvl[g] <= 1'b0;
        pin_chg[g] <= 1'b0;
      end
      else
      begin
        pin_s1[g]  <= (g < 6) ? STOP_SW_I[g % 6] : IN_PIN_I[(g + 2) % 8];
        pin_s2[g]  <= pin_s1[g];
        pin_s3[g]  <= pin_s2[g];
        pin_chg[g] <= (pin_s2[g] == pin_s3[g]) && (pin_s3[g] != pin_lvl[g]);
        if (pin_s2[g] == pin_s3[g])
          pin_lvl[g] <= pin_s3[g];
      end
    end
  end

  // Millisecond tick and interval timers
  logic [31:0] div_r;
  logic        tick_r;
  logic [TIMER_W-1:0] tmr_cnt [sim_pkg::NTIMERS];
  logic [TIMER_W-1:0] tmr_ival [sim_pkg::NTIMERS];
  logic [sim_pkg::NTIMERS-1:0] tmr_evt;
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      div_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (div_r == 32'(TICK_CYCLES - 1));
      div_r  <= (div_r == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div_r + 32'h0000_0001;
    end
  end
  for (g = 0; g < sim_pkg::NTIMERS; g++)
  begin : g_tmr
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
      if (!RSTN_I)
      begin
        tmr_ival[g] <= '0;
        tmr_cnt[g]  <= '0;
        tmr_evt[g]  <= 1'b0;
      end
      else
      begin
        tmr_evt[g] <= 1'b0;
        if (cmd_exec && op == sim_pkg::OP_SET_GLOBAL && bank == sim_pkg::IRQ_BANK
            && typ == sim_pkg::FIRST_TIMER_IRQ_SYM + 8'(g))
        begin
          tmr_ival[g] <= value_r[TIMER_W-1:0]; // [R9]
          tmr_cnt[g]  <= '0;
        end
        else if (tick_r && tmr_ival[g] != '0)
        begin
          if (tmr_cnt[g] + 1'b1 >= tmr_ival[g])
          begin
            tmr_cnt[g] <= '0;
            tmr_evt[g] <= 1'b1;
          end
          else
            tmr_cnt[g] <= tmr_cnt[g] + 1'b1;
        end
      end
    end
  end

  // Source bit order follows the interrupt number table
  assign evt = {pin_chg[13:6], pin_chg[5:0], EVT_DEV_I, EVT_STALL_I, EVT_POS_I, tmr_evt}; // [R1] [R2] [R3]

  // Pending, enable and vector state
  logic [NSRC-1:0] pend_r, en_r, vvalid_r;
  logic [15:0]     vaddr_r [NSRC];
  logic            glob_en_r;

  for (g = 0; g < NSRC; g++)
  begin : g_src
    assign match[g] = (typ == sim_pkg::SRC_NUM[g]);
    assign req[g]   = pend_r[g] && en_r[g] && vvalid_r[g]; // [R5]
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
      if (!RSTN_I)
      begin
        pend_r[g]   <= 1'b0;
        en_r[g]     <= 1'b0;
        vvalid_r[g] <= 1'b0;
        vaddr_r[g]  <= 16'h0000;
      end
      else
      begin
        pend_r[g] <= evt[g] || (pend_r[g] && !(take && sel == 5'(g)));
        if (cmd_exec && match[g] && op == sim_pkg::OP_IRQ_ENABLE)
          en_r[g] <= 1'b1; // [R19]
        else if (cmd_exec && match[g] && op == sim_pkg::OP_IRQ_DISABLE)
          en_r[g] <= 1'b0;
        if (cmd_exec && match[g] && op == sim_pkg::OP_SET_VECTOR)
        begin
          vvalid_r[g] <= 1'b1;
          vaddr_r[g]  <= value_r[15:0];
        end
      end
    end
  end

  // Lowest source number wins
  always_comb
  begin
    sel = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--)
      if (req[i])
        sel = 5'(i);
  end
  assign take = glob_en_r && !IRQ_ACTIVE_O && (|req) && !wr; // [R4] [R7]

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      glob_en_r <= 1'b0;
      value_r   <= 32'h0000_0000;
    end
    else
    begin
      if (cmd_exec && typ == sim_pkg::ALL_IRQ_SYM && op == sim_pkg::OP_IRQ_ENABLE)
        glob_en_r <= 1'b1; // [R4]
      else if (cmd_exec && typ == sim_pkg::ALL_IRQ_SYM && op == sim_pkg::OP_IRQ_DISABLE)
        glob_en_r <= 1'b0;
      if (wr && ADR_I == sim_pkg::OFS_VALUE)
        value_r <= merge(value_r, DAT_I, SEL_I);
    end
  end

  // Program context with shadow copy
  logic [31:0] acc_r, x_r, sh_acc_r, sh_x_r;
  logic [3:0]  flg_r, sh_flg_r;
  logic [15:0] pc_r, sh_pc_r;
  logic [7:0]  last_num_r;
  logic [31:0] pc_wr;
  assign pc_wr = merge({16'h0000, pc_r}, DAT_I, SEL_I);
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      acc_r <= '0; x_r <= '0; flg_r <= '0; pc_r <= '0;
      sh_acc_r <= '0; sh_x_r <= '0; sh_flg_r <= '0; sh_pc_r <= '0;
      IRQ_ACTIVE_O <= 1'b0;
      last_num_r   <= 8'h00;
    end
    else if (take)
    begin
      sh_acc_r     <= acc_r; // [R6]
      sh_x_r       <= x_r;
      sh_flg_r     <= flg_r;
      sh_pc_r      <= pc_r;
      pc_r         <= vaddr_r[sel];
      last_num_r   <= sim_pkg::SRC_NUM[sel];
      IRQ_ACTIVE_O <= 1'b1; // [R7]
    end
    else if (irq_return_cmd_exec)
    begin
      acc_r        <= sh_acc_r; // [R8]
      x_r          <= sh_x_r;
      flg_r        <= sh_flg_r;
      pc_r         <= sh_pc_r;
      IRQ_ACTIVE_O <= 1'b0;
    end
    else if (wr)
    begin
      if (ADR_I == sim_pkg::OFS_ACC)
        acc_r <= merge(acc_r, DAT_I, SEL_I);
      if (ADR_I == sim_pkg::OFS_XREG)
        x_r <= merge(x_r, DAT_I, SEL_I);
      if (ADR_I == sim_pkg::OFS_FLAGS && SEL_I[0])
        flg_r <= DAT_I[3:0];
      if (ADR_I == sim_pkg::OFS_PC)
        pc_r <= pc_wr[15:0];
    end
  end

  // Wishbone answer, one wait state, unmapped reads zero
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end
    else
    begin
      ACK_O <= CYC_I && STB_I && !ACK_O;
      unique case (ADR_I)
        sim_pkg::OFS_VALUE:  DAT_O <= value_r;
        sim_pkg::OFS_ACC:    DAT_O <= acc_r;
        sim_pkg::OFS_XREG:   DAT_O <= x_r;
        sim_pkg::OFS_FLAGS:  DAT_O <= {28'h0000000, flg_r};
        sim_pkg::OFS_PC:     DAT_O <= {16'h0000, pc_r};
        sim_pkg::OFS_STATUS: DAT_O <= {16'h0000, last_num_r, 6'h00, glob_en_r, IRQ_ACTIVE_O};
        sim_pkg::OFS_PEND:   DAT_O <= {6'h00, pend_r};
        sim_pkg::OFS_ENABLE: DAT_O <= {6'h00, en_r};
        sim_pkg::OFS_MOTION: DAT_O <= {29'h00000000, VEL_MODE_O};
        default:             DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  // Host frame path
  logic [63:0] head;
  logic        sum_ok, rx_done;
  sim_frame_rx #(.FRAME_LEN(sim_pkg::FRAME_LEN)) u_rx (
    .clk_i    (CLK_I),
    .rstn_i   (RSTN_I),
    .take_i   (RX_VALID_I && RX_READY_O),
    .byte_i   (RX_BYTE_I),
    .head_o   (head),
    .sum_ok_o (sum_ok),
    .done_o   (rx_done)
  );

  logic [7:0]  f_addr, f_op, f_typ, f_axis;
  logic signed [31:0] f_val;
  logic        op_known, fields_ok;
  assign f_addr    = head[63:56];
  assign f_op      = head[55:48];
  assign f_typ     = head[47:40];
  assign f_axis    = head[39:32];
  assign f_val     = head[31:0]; // [R17]
  assign op_known  = f_op == sim_pkg::OP_ROTATE_RIGHT || f_op == sim_pkg::OP_ROTATE_LEFT
                     || f_op == sim_pkg::OP_SOFT_STOP; // [R22]
  assign fields_ok = f_typ == sim_pkg::MOTION_TYPE && f_axis < 8'(sim_pkg::NAXES)
                     && (f_op == sim_pkg::OP_SOFT_STOP
                         || (f_val <= sim_pkg::VEL_LIMIT && f_val >= -sim_pkg::VEL_LIMIT)); // [R15]

  sim_pkg::sim_fsm_e st_r;
  logic [7:0]  rep_st_r, rep_op_r;
  logic [3:0]  tx_idx_r;
  logic [31:0] vel_r;

  function automatic logic [7:0] rep_byte(input logic [3:0] i, input logic [7:0] s,
                                          input logic [7:0] o);
    unique case (i)
      4'h0:    return REPLY_ADDR;
      4'h1:    return MODULE_ADDR;
      4'h2:    return s;
      4'h3:    return o;
      4'h8:    return REPLY_ADDR + MODULE_ADDR + s + o;
      default: return 8'h00;
    endcase
  endfunction

  // Frame sequencer; accumulator is never written here [R20]
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      st_r       <= sim_pkg::F_IDLE;
      RX_READY_O <= 1'b0;
      TX_VALID_O <= 1'b0;
      TX_BYTE_O  <= 8'h00;
      tx_idx_r   <= 4'h0;
      rep_st_r   <= 8'h00;
      rep_op_r   <= 8'h00;
      vel_r      <= 32'h0000_0000;
      MODE_STB_O <= 1'b0;
      PAR_STB_O  <= 1'b0;
      AXIS_O     <= 2'b00;
      PAR_NUM_O  <= 8'h00;
      PAR_VAL_O  <= 32'h0000_0000;
      VEL_MODE_O <= 3'b000;
    end
    else
    begin
      MODE_STB_O <= 1'b0;
      PAR_STB_O  <= 1'b0;
      unique case (st_r)
        sim_pkg::F_IDLE:
        begin
          RX_READY_O <= !rx_done;
          if (rx_done && f_addr == MODULE_ADDR)
          begin
            RX_READY_O <= 1'b0;
            rep_op_r   <= f_op;
            AXIS_O     <= f_axis[1:0];
            vel_r      <= (f_op == sim_pkg::OP_ROTATE_LEFT) ? -f_val : f_val; // [R14]
            if (f_op == sim_pkg::OP_SOFT_STOP)
              vel_r <= 32'h0000_0000; // [R16]
            if (!sum_ok)
              rep_st_r <= sim_pkg::ST_BAD_SUM; // [R21]
            else if (!op_known)
              rep_st_r <= sim_pkg::ST_BAD_CMD;
            else if (!fields_ok)
              rep_st_r <= sim_pkg::ST_BAD_VAL;
            else
              rep_st_r <= sim_pkg::ST_OK; // [R18]
            st_r <= (sum_ok && op_known && fields_ok) ? sim_pkg::F_MODE : sim_pkg::F_REPLY;
          end
        end
        sim_pkg::F_MODE:
        begin
          MODE_STB_O         <= 1'b1; // [R13]
          VEL_MODE_O[AXIS_O] <= 1'b1;
          st_r               <= sim_pkg::F_PAR;
        end
        sim_pkg::F_PAR:
        begin
          PAR_STB_O <= 1'b1; // [R13]
          PAR_NUM_O <= sim_pkg::PAR_TARGET_VEL;
          PAR_VAL_O <= vel_r;
          st_r      <= sim_pkg::F_REPLY;
        end
        sim_pkg::F_REPLY:
        begin
          if (!TX_VALID_O)
          begin
            TX_VALID_O <= 1'b1;
            TX_BYTE_O  <= rep_byte(4'h0, rep_st_r, rep_op_r);
            tx_idx_r   <= 4'h0;
          end
          else if (TX_READY_I)
          begin
            if (tx_idx_r == 4'(sim_pkg::FRAME_LEN - 1))
            begin
              TX_VALID_O <= 1'b0;
              RX_READY_O <= 1'b1;
              st_r       <= sim_pkg::F_IDLE;
            end
            else
            begin
              tx_idx_r  <= tx_idx_r + 4'h1;
              TX_BYTE_O <= rep_byte(tx_idx_r + 4'h1, rep_st_r, rep_op_r);
            end
          end
        end
      endcase
    end
  end

  // Checks
  sequence s_mode_par;
    MODE_STB_O ##1 PAR_STB_O && PAR_NUM_O == sim_pkg::PAR_TARGET_VEL;
  endsequence
  property p_rotate_order;
    @(posedge CLK_I) disable iff (!RSTN_I)
      st_r == sim_pkg::F_IDLE && rx_done && f_addr == MODULE_ADDR && sum_ok && op_known
      && fields_ok |=> ##1 s_mode_par ##1 st_r == sim_pkg::F_REPLY && rep_st_r == sim_pkg::ST_OK;
  endproperty
  a_rotate_order: assert property (p_rotate_order) else $error("Mode/velocity order broken"); // [R13]
  property p_left_negates;
    @(posedge CLK_I) disable iff (!RSTN_I)
      PAR_STB_O && rep_op_r == sim_pkg::OP_ROTATE_LEFT |-> PAR_VAL_O == -$past(f_val, 4);
  endproperty
  a_left_negates: assert property (p_left_negates) else $error("Left velocity not negated"); // [R14]
  property p_stop_zero;
    @(posedge CLK_I) disable iff (!RSTN_I)
      PAR_STB_O && rep_op_r == sim_pkg::OP_SOFT_STOP |-> PAR_VAL_O == 32'h0000_0000 && $past(MODE_STB_O);
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("Stop target not zero"); // [R16]
  property p_take_vector;
    @(posedge CLK_I) disable iff (!RSTN_I)
      take |=> IRQ_ACTIVE_O && pc_r == $past(vaddr_r[sel]) && sh_pc_r == $past(pc_r);
  endproperty
  a_take_vector: assert property (p_take_vector) else $error("Vector not entered"); // [R5]
  property p_save_ctx;
    @(posedge CLK_I) disable iff (!RSTN_I)
      take |=> sh_acc_r == $past(acc_r) && sh_x_r == $past(x_r) && sh_flg_r == $past(flg_r);
  endproperty
  a_save_ctx: assert property (p_save_ctx) else $error("Context not saved"); // [R6]
  property p_no_nest;
    @(posedge CLK_I) disable iff (!RSTN_I)
      IRQ_ACTIVE_O && !irq_return_cmd_exec |=> IRQ_ACTIVE_O && $stable(sh_pc_r);
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("Nested interrupt"); // [R7]
  property p_restore;
    @(posedge CLK_I) disable iff (!RSTN_I)
      irq_return_cmd_exec |=> !IRQ_ACTIVE_O && acc_r == $past(sh_acc_r) && pc_r == $past(sh_pc_r);
  endproperty
  a_restore: assert property (p_restore) else $error("Context not restored"); // [R8]
  property p_global_gate;
    @(posedge CLK_I) disable iff (!RSTN_I)
      $rose(IRQ_ACTIVE_O) |-> $past(glob_en_r) && $past(req != '0);
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("Handler without enable"); // [R4]
  property p_bad_sum;
    @(posedge CLK_I) disable iff (!RSTN_I)
      st_r == sim_pkg::F_IDLE && rx_done && f_addr == MODULE_ADDR && !sum_ok
      |=> st_r == sim_pkg::F_REPLY && rep_st_r == sim_pkg::ST_BAD_SUM ##1 !PAR_STB_O;
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("Bad frame not rejected"); // [R21]
  property p_acc_frame;
    @(posedge CLK_I) disable iff (!RSTN_I)
      st_r != sim_pkg::F_IDLE && !wr && !irq_return_cmd_exec |=> $stable(acc_r);
  endproperty
  a_acc_frame: assert property (p_acc_frame) else $error("Accumulator disturbed"); // [R20]
endmodule

// ---- rtl/sim_frame_rx.sv ----
// Collects host bytes into a nine byte frame and checks its sum.
// Assumes byte strobes come from logic on the same clock.
`timescale 1ns/10ps
module sim_frame_rx #(
  parameter int FRAME_LEN = sim_pkg::FRAME_LEN
) (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   take_i,
  input  wire logic [7:0]             byte_i,
  output logic      [8*FRAME_LEN-9:0] head_o,
  output logic                        sum_ok_o,
  output logic                        done_o
);
  logic [7:0] buf_r [FRAME_LEN-1];
  logic [7:0] sum_r;
  logic [3:0] cnt_r;

  initial
  begin
    if (FRAME_LEN < 2 || FRAME_LEN > 15)
      $error("FRAME_LEN out of range");
  end

  // Byte counting and running sum
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_r    <= 4'h0;
      sum_r    <= 8'h00;
      done_o   <= 1'b0;
      sum_ok_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (take_i)
      begin
        if (cnt_r == 4'(FRAME_LEN - 1))
        begin
          done_o   <= 1'b1;
          sum_ok_o <= (sum_r == byte_i); // [R21]
          cnt_r    <= 4'h0;
          sum_r    <= 8'h00;
        end
        else
        begin
          cnt_r <= cnt_r + 4'h1;
          sum_r <= sum_r + byte_i;
        end
      end
    end
  end

  // Frame bytes, first byte in the top lane
  genvar g;
  for (g = 0; g < FRAME_LEN - 1; g++)
  begin : g_byte
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
      if (!rstn_i)
        buf_r[g] <= 8'h00;
      else if (take_i && cnt_r == 4'(g))
        buf_r[g] <= byte_i; // [R17]
    end
    assign head_o[8*(FRAME_LEN-1-g)-1 -: 8] = buf_r[g];
  end
endmodule

// ---- rtl/sim_pkg.sv ----
// Shared constants for the program interrupt and motion command slice.
// Assumes a single 40 MHz clock domain and byte-wide host frames.
package sim_pkg;
  localparam int NSRC      = 26;
  localparam int NAXES     = 3;
  localparam int NTIMERS   = 3;
  localparam int NPINS     = 14;
  localparam int FRAME_LEN = 9;

  // Instruction codes
  localparam logic [7:0] OP_ROTATE_RIGHT = 8'h01;
  localparam logic [7:0] OP_ROTATE_LEFT  = 8'h02;
  localparam logic [7:0] OP_SOFT_STOP    = 8'h03;
  localparam logic [7:0] OP_SET_GLOBAL   = 8'h09;
  localparam logic [7:0] OP_IRQ_ENABLE   = 8'h19;
  localparam logic [7:0] OP_IRQ_DISABLE  = 8'h1A;
  localparam logic [7:0] OP_SET_VECTOR   = 8'h25;
  localparam logic [7:0] OP_IRQ_RETURN   = 8'h26;

  localparam logic [7:0] MOTION_TYPE     = 8'h00;
  localparam logic [7:0] IRQ_BANK        = 8'h03;
  localparam logic [7:0] ALL_IRQ_SYM     = 8'hFF;
  localparam logic [7:0] FIRST_TIMER_IRQ_SYM = 8'h00;
  localparam logic [7:0] PAR_TARGET_VEL  = 8'h02;
  localparam logic signed [31:0] VEL_LIMIT = 32'sh000007FF;

  // Reply status codes
  localparam logic [7:0] ST_OK      = 8'h64;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_VAL = 8'h04;

  // Interrupt number of each source bit
  localparam logic [7:0] SRC_NUM [NSRC] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h0F, 8'h10, 8'h11, 8'h15, 8'h16, 8'h17,
    8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20,
    8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E};

  // Register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_VALUE  = 8'h04;
  localparam logic [7:0] OFS_ACC    = 8'h08;
  localparam logic [7:0] OFS_XREG   = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_PC     = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_PEND   = 8'h1C;
  localparam logic [7:0] OFS_ENABLE = 8'h20;
  localparam logic [7:0] OFS_MOTION = 8'h24;

  // Timer base tick
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  typedef enum logic [1:0] {F_IDLE, F_MODE, F_PAR, F_REPLY} sim_fsm_e;
endpackage

// ---- tb/sim_host.sv ----
// Host model: sends nine byte command frames, takes reply bytes.
// Assumes the device clock and a ready/valid byte link.
`timescale 1ns/10ps
module sim_host (
  input  wire logic       clk_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  output logic            tx_ready_o
);
  initial
  begin
    rx_byte_o  = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end

  // Slow sink: accepts on every other cycle
  always @(posedge clk_i)
    tx_ready_o <= ~tx_ready_o;

  task automatic send(input logic [7:0] ins, ty, ax, input logic [31:0] v, input bit bad);
    logic [7:0] f [9];
    f = '{8'h01, ins, ty, ax, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++)
      f[8] = f[8] + f[i];
    if (bad)
      f[8] = ~f[8];
    for (int i = 0; i < 9; i++)
    begin
      rx_byte_o  <= f[i];
      rx_valid_o <= 1'b1;
      @(posedge clk_i);
      while (rx_ready_i !== 1'b1)
        @(posedge clk_i);
    end
    rx_valid_o <= 1'b0;
    rx_byte_o  <= ~f[8];
  endtask
endmodule

// ---- tb/tb.sv ----
// Testbench: host motion frames, bus program setup, interrupt entry and return.
// Assumes the core with a short timer tick.
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00, rxb, txb, pnum;
  logic [31:0] dat = 32'h0, dat_o, pval;
  logic [2:0]  pos = 3'h0, stl = 3'h0;
  logic [1:0]  axis;
  logic        ack, rxv, rxr, txv, txr, pstb, act, mstb;
  logic [5:0]  sw = 6'h00;
  int          fails = 0, samples_checked = 0, cycles = 0;
  integer      seed = 32'h4340;
  logic [31:0] v;
  logic [63:0] rep_q[$], par_q[$], bus_q[$];

  always #12.5 clk = ~clk;

  sim_core #(.TICK_CYCLES(4)) u_dut (.CLK_I(clk), .RSTN_I(rstn), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
    .RX_BYTE_I(rxb), .RX_VALID_I(rxv), .RX_READY_O(rxr), .TX_BYTE_O(txb), .TX_VALID_O(txv),
    .TX_READY_I(txr), .EVT_POS_I(pos), .EVT_STALL_I(stl), .EVT_DEV_I(3'h0), .STOP_SW_I(sw),
    .IN_PIN_I(8'h00), .MODE_STB_O(mstb), .AXIS_O(axis), .PAR_STB_O(pstb), .PAR_NUM_O(pnum),
    .PAR_VAL_O(pval), .VEL_MODE_O(), .IRQ_ACTIVE_O(act));

  sim_host u_host (.clk_i(clk), .rx_byte_o(rxb), .rx_valid_o(rxv), .rx_ready_i(rxr),
    .tx_ready_o(txr));

  task automatic check(input string n, input logic [63:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (txv === 1'b1 && txr === 1'b1)
      check("reply", txb, rep_q.pop_front());
    if (mstb === 1'b1)
      check("mode", axis, par_q[0][41:40]);
    if (pstb === 1'b1)
      check("param", {axis, pnum, pval}, par_q.pop_front());
    if (ack === 1'b1 && we === 1'b0 && adr === 8'h18)
      check("active", act, bus_q[0][0]);
    if (ack === 1'b1 && we === 1'b0)
      check("rdata", dat_o, bus_q.pop_front());
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w)
      bus_q.push_back(d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= w ? d : 32'h0;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic frame(input logic [7:0] ins, ty, ax, input logic [31:0] v, input bit bad,
                       input logic [7:0] st);
    logic [7:0] s;
    s = 8'h03 + st + ins;
    rep_q = {rep_q, 64'h02, 64'h01, 64'(st), 64'(ins), 64'h0, 64'h0, 64'h0, 64'h0, 64'(s)};
    if (st == sim_pkg::ST_OK)
      par_q.push_back({ax[1:0], 8'h02, ins == 8'h02 ? -v : ins == 8'h03 ? 32'h0 : v});
    u_host.send(ins, ty, ax, v, bad);
    while (rep_q.size() != 0)
      @(posedge clk);
    @(posedge clk);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wb(1, 8'h08, 32'h1234);
    frame(8'h01, 8'h00, 8'h00, 32'd1000, 0, 8'h64);
    v = $random(seed) % 2048;
    frame(8'h02, 8'h00, 8'h02, v, 0, 8'h64);
    frame(8'h03, 8'h00, 8'h01, $random(seed), 0, 8'h64);
    frame(8'h01, 8'h00, 8'h00, 32'd2047, 0, 8'h64);
    frame(8'h01, 8'h00, 8'h00, 32'd2048, 0, 8'h04);
    frame(8'h02, 8'h00, 8'h03, 32'd5, 0, 8'h04);
    frame(8'h03, 8'h01, 8'h00, 32'd0, 0, 8'h04);
    frame(8'h01, 8'h00, 8'h00, 32'd7, 1, 8'h01);
    frame(8'h07, 8'h00, 8'h00, 32'd0, 0, 8'h02);
    wb(0, 8'h24, 32'h7);
    wb(0, 8'h08, 32'h1234);
    wb(1, 8'h04, 32'h40);
    wb(1, 8'h00, 32'h0325);
    wb(1, 8'h04, 32'h80);
    wb(1, 8'h00, 32'h0F25);
    wb(1, 8'h00, 32'h0319);
    wb(1, 8'h00, 32'h0F19);
    wb(1, 8'h14, 32'h10);
    pos <= 3'h1;
    @(posedge clk);
    pos <= 3'h0;
    repeat (4) @(posedge clk);
    wb(0, 8'h18, 32'h0);
    wb(1, 8'h00, 32'hFF19);
    repeat (3) @(posedge clk);
    wb(0, 8'h18, 32'h0303);
    wb(0, 8'h14, 32'h40);
    stl <= 3'h1;
    @(posedge clk);
    stl <= 3'h0;
    repeat (4) @(posedge clk);
    wb(0, 8'h18, 32'h0303);
    wb(1, 8'h08, 32'hAAAA);
    wb(1, 8'h00, 32'h26);
    repeat (3) @(posedge clk);
    wb(0, 8'h18, 32'h0F03);
    wb(0, 8'h08, 32'h1234);
    wb(1, 8'h00, 32'h26);
    wb(0, 8'h14, 32'h10);
    sw <= 6'h01;
    repeat (8) @(posedge clk);
    wb(0, 8'h1C, 32'h1000);
    wb(1, 8'h04, 32'h1);
    wb(1, 8'h00, 32'h0003_0009);
    wb(1, 8'h04, 32'h60);
    wb(1, 8'h00, 32'h0025);
    wb(1, 8'h00, 32'h0019);
    repeat (3) @(posedge clk);
    wb(0, 8'h18, 32'h0003);
    wb(0, 8'h14, 32'h60);
    check("par_left", par_q.size(), 0);
    summarize();
  end
endmodule
